// file: prs_cfg.svh
// register map, reset values, field positions and sizes of the redundancy statistics bank
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH

// ==========================================================================
// register byte addresses
`define PRS_ADDR_HIST_DATA 32'h44053d24
`define PRS_ADDR_AGING 32'h44053d2c
`define PRS_ADDR_LATE 32'h44053d30
`define PRS_ADDR_WLAN_A 32'h44053d34
`define PRS_ADDR_WLAN_B 32'h44053d38
`define PRS_ADDR_DUP_A 32'h44053d3c
`define PRS_ADDR_DUP_B 32'h44053d40
`define PRS_ADDR_LOW_A 32'h44053d44
`define PRS_ADDR_LOW_B 32'h44053d48
`define PRS_ADDR_OOS_A 32'h44053d4c
`define PRS_ADDR_CONFIG 32'h44053d60
`define PRS_ADDR_IRQ_STAT 32'h44053d64
`define PRS_ADDR_IRQ_MASK 32'h44053d68

// ==========================================================================
// reset values
`define PRS_RST_HIST_DATA 32'h00000000
`define PRS_RST_COUNT 32'h00000000
`define PRS_RST_ENABLE 1'h0
`define PRS_RST_DUP_WINDOW 16'h0080
`define PRS_RST_IRQ_MASK 4'h0

// ==========================================================================
// field positions
`define PRS_CFG_ENA_BIT 0
`define PRS_CFG_WIN_LSB 16
`define PRS_CFG_WIN_MSB 31
`define PRS_IRQ_LATE_BIT 0
`define PRS_IRQ_DUP_BIT 1
`define PRS_IRQ_LOW_BIT 2
`define PRS_IRQ_OOS_BIT 3

// ==========================================================================
// sizes and sequence arithmetic
`define PRS_NUM_PORTS 5
`define PRS_NUM_LANS 2
`define PRS_NUM_IRQ 4
`define PRS_SEQ_HALF 16'h8000
`define PRS_CNT_ONE 32'h00000001

`endif

// file: prs_pkg.sv
// state types of the redundancy statistics bank
`default_nettype none
`include "prs_cfg.svh"
package prs_pkg;

    // register bank state
    typedef struct packed {
        logic [31:0] hist_data;
        logic [`PRS_NUM_IRQ-1:0] irq_mask;
        logic [`PRS_NUM_IRQ-1:0] irq_stat;
        logic [`PRS_NUM_PORTS-1:0] late_flags;
        logic enable;
        logic [15:0] dup_window;
        logic [31:0] prdata;
        logic pslverr;
        logic irq;
    } prs_regs_t;

    // frame counter state
    typedef struct packed {
        logic [`PRS_NUM_LANS-1:0][31:0] dup_cnt;
        logic [`PRS_NUM_LANS-1:0][31:0] low_cnt;
        logic [31:0] oos_cnt;
        logic dup_hit;
        logic low_hit;
        logic oos_hit;
    } prs_cnt_t;

    // late lookup transmit state
    typedef struct packed {
        logic [`PRS_NUM_PORTS-1:0] tx_dup;
        logic [`PRS_NUM_PORTS-1:0] tx_rct;
        logic [`PRS_NUM_PORTS-1:0] late_set;
    } prs_lkp_t;

endpackage
`default_nettype wire

// file: prs_evt_if.sv
// signals shared between the register bank and its counter and lookup helpers
`timescale 1ns/10ps
`default_nettype none
`include "prs_cfg.svh"
interface prs_evt_if;
    logic enable;
    logic [15:0] dup_window;
    logic [`PRS_NUM_LANS-1:0] acc;
    logic [`PRS_NUM_LANS-1:0] dup;
    logic [`PRS_NUM_LANS-1:0] unexp;
    logic [`PRS_NUM_LANS-1:0][15:0] seq;
    logic [`PRS_NUM_LANS-1:0][15:0] last;
    logic [`PRS_NUM_LANS-1:0][31:0] dup_cnt;
    logic [`PRS_NUM_LANS-1:0][31:0] low_cnt;
    logic [31:0] oos_cnt;
    logic dup_hit;
    logic low_hit;
    logic oos_hit;
    logic [`PRS_NUM_PORTS-1:0] fwd;
    logic [`PRS_NUM_PORTS-1:0] looked_up;
    logic [`PRS_NUM_PORTS-1:0] tx_dup;
    logic [`PRS_NUM_PORTS-1:0] tx_rct;
    logic [`PRS_NUM_PORTS-1:0] late_set;

    // register bank side
    modport top (output enable, dup_window, acc, dup, unexp, seq, last, fwd, looked_up,
                 input dup_cnt, low_cnt, oos_cnt, dup_hit, low_hit, oos_hit,
                 input tx_dup, tx_rct, late_set);
    // counter side
    modport cnt (input dup_window, acc, dup, unexp, seq, last,
                 output dup_cnt, low_cnt, oos_cnt, dup_hit, low_hit, oos_hit);
    // lookup side
    modport lkp (input enable, fwd, looked_up, output tx_dup, tx_rct, late_set);
endinterface // prs_evt_if
`default_nettype wire

// file: prs_lan_counters.sv
// per-lan frame statistics counters
`timescale 1ns/10ps
`default_nettype none
module prs_lan_counters
    import prs_pkg::*;
(
    input wire logic clock_in,
    input wire logic rstn_in,
    prs_evt_if.cnt evt_if
);
    prs_cnt_t st_ff;
    prs_cnt_t nxt_st;
    logic [`PRS_NUM_LANS-1:0] below;
    logic [`PRS_NUM_LANS-1:0][15:0] age;

    // ======================================================================
    // below-window test per lan, modulo sequence distance behind the last
    generate
        for (genvar l = 0; l < `PRS_NUM_LANS; l++)
        begin : g_lan
            assign age[l] = evt_if.last[l] - evt_if.seq[l];
            assign below[l] = evt_if.acc[l] & (age[l] > evt_if.dup_window)
                              & (age[l] < `PRS_SEQ_HALF);
        end
    endgenerate

    // ======================================================================
    // counter update, one step per qualifying frame
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.dup_hit = 1'b0;
        nxt_st.low_hit = 1'b0;
        nxt_st.oos_hit = 1'b0;
        for (int l = 0; l < `PRS_NUM_LANS; l++)
        begin
            if (evt_if.dup[l])
            begin
                nxt_st.dup_cnt[l] = st_ff.dup_cnt[l] + `PRS_CNT_ONE;
                nxt_st.dup_hit = 1'b1;
            end
            if (below[l])
            begin
                nxt_st.low_cnt[l] = st_ff.low_cnt[l] + `PRS_CNT_ONE;
                nxt_st.low_hit = 1'b1;
            end
        end
        // lan a unexpected count also steps with its below-window count
        if (evt_if.acc[0] & (evt_if.unexp[0] | below[0]))
        begin
            nxt_st.oos_cnt = st_ff.oos_cnt + `PRS_CNT_ONE;
            nxt_st.oos_hit = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign evt_if.dup_cnt = st_ff.dup_cnt;
    assign evt_if.low_cnt = st_ff.low_cnt;
    assign evt_if.oos_cnt = st_ff.oos_cnt;
    assign evt_if.dup_hit = st_ff.dup_hit;
    assign evt_if.low_hit = st_ff.low_hit;
    assign evt_if.oos_hit = st_ff.oos_hit;
endmodule // prs_lan_counters
`default_nettype wire

// file: prs_late_lookup.sv
// transmit decision for frames toward the redundant ports per source port
`timescale 1ns/10ps
`default_nettype none
module prs_late_lookup
    import prs_pkg::*;
(
    input wire logic clock_in,
    input wire logic rstn_in,
    prs_evt_if.lkp evt_if
);
    prs_lkp_t st_ff;
    prs_lkp_t nxt_st;

    // ======================================================================
    // a forwarded frame is duplicated only while enabled; its trailer only if lookup done
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tx_dup = evt_if.fwd & {`PRS_NUM_PORTS{evt_if.enable}};
        nxt_st.tx_rct = nxt_st.tx_dup & evt_if.looked_up;
        nxt_st.late_set = nxt_st.tx_dup & ~evt_if.looked_up;
    end

    // state register
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign evt_if.tx_dup = st_ff.tx_dup;
    assign evt_if.tx_rct = st_ff.tx_rct;
    assign evt_if.late_set = st_ff.late_set;
endmodule // prs_late_lookup
`default_nettype wire

// file: prs_redundancy_stats_regs.sv
// apb register bank for redundancy status, late lookup flags and lan statistics
//
// Contract
// - 32-bit read/write history memory data register.
// - completed memory read loads the data register.
// - read-only 16-bit next aging scan index.
// - five sticky per-port late lookup flags.
// - writing one clears a flag; zero keeps.
// - all late flags clear while redundancy disabled.
// - late lookup: duplicate frame, omit trailer.
// - per-lan 32-bit duplicate drop counts.
// - per-lan 32-bit below-window sequence counts.
// - lan a 32-bit unexpected sequence count.
// - lan a below-window step also steps its unexpected count.
// - wrong-lan registers mapped, always read zero.
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module prs_redundancy_stats_regs
    import prs_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // interrupt
    output logic irq_out,
    // history memory controller
    input wire logic hist_rd_done_in,
    input wire logic [31:0] hist_rd_data_in,
    output logic [31:0] hist_wr_data_out,
    input wire logic [15:0] age_addr_in,
    // configuration seen by the datapath
    output logic redundancy_enable_out,
    output logic [15:0] duplicate_window_out,
    // per-port transmit toward the redundant ports
    input wire logic [`PRS_NUM_PORTS-1:0] fwd_in,
    input wire logic [`PRS_NUM_PORTS-1:0] lookup_done_in,
    output logic [`PRS_NUM_PORTS-1:0] tx_dup_out,
    output logic [`PRS_NUM_PORTS-1:0] tx_rct_out,
    // lan a frame events
    input wire logic acc_a_in,
    input wire logic dup_a_in,
    input wire logic unexp_a_in,
    input wire logic [15:0] seq_a_in,
    input wire logic [15:0] last_a_in,
    // lan b frame events
    input wire logic acc_b_in,
    input wire logic dup_b_in,
    input wire logic unexp_b_in,
    input wire logic [15:0] seq_b_in,
    input wire logic [15:0] last_b_in
);

    // ======================================================================
    // declarations
    prs_regs_t st_ff;
    prs_regs_t nxt_st;
    prs_evt_if evt ();
    logic apb_setup;
    logic apb_access;
    logic apb_wr;
    logic apb_rd;
    logic addr_hit;
    logic [31:0] rd_word;
    logic [31:0] cfg_word;
    logic [31:0] cfg_new;
    logic [`PRS_NUM_PORTS-1:0] late_clr;
    logic [`PRS_NUM_IRQ-1:0] irq_evt;
    logic [`PRS_NUM_IRQ-1:0] irq_clr;

    // ======================================================================
    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] strb_merge(input logic [31:0] old_word,
                                               input logic [31:0] new_word,
                                               input logic [3:0] strb);
        logic [31:0] mask;
        mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        strb_merge = (old_word & ~mask) | (new_word & mask);
    endfunction

    // ======================================================================
    // helper modules
    // sequence and duplicate statistics
    prs_lan_counters u_counters
    (
        .clock_in (clock_in),
        .rstn_in (rstn_in),
        .evt_if (evt.cnt)
    );

    // transmit decision on late source lookups
    prs_late_lookup u_lookup
    (
        .clock_in (clock_in),
        .rstn_in (rstn_in),
        .evt_if (evt.lkp)
    );

    // datapath events pass straight in; they share this clock
    assign evt.enable = st_ff.enable;
    assign evt.dup_window = st_ff.dup_window;
    assign evt.acc = {acc_b_in, acc_a_in};
    assign evt.dup = {dup_b_in, dup_a_in};
    assign evt.unexp = {unexp_b_in, unexp_a_in};
    assign evt.seq = {seq_b_in, seq_a_in};
    assign evt.last = {last_b_in, last_a_in};
    assign evt.fwd = fwd_in;
    assign evt.looked_up = lookup_done_in;

    // ======================================================================
    // apb phase decode
    assign apb_setup = psel_in & ~penable_in;
    assign apb_access = psel_in & penable_in;
    assign apb_wr = apb_access & pwrite_in;
    assign apb_rd = apb_access & ~pwrite_in;

    // packed view of the configuration register
    always_comb
    begin
        cfg_word = 32'h00000000;
        cfg_word[`PRS_CFG_ENA_BIT] = st_ff.enable;
        cfg_word[`PRS_CFG_WIN_MSB:`PRS_CFG_WIN_LSB] = st_ff.dup_window;
        cfg_new = strb_merge(cfg_word, pwdata_in, pstrb_in);
    end

    // ======================================================================
    // read data and address decode, taken in the setup phase
    always_comb
    begin
        addr_hit = 1'b1;
        rd_word = 32'h00000000;
        case (paddr_in)
            `PRS_ADDR_HIST_DATA:
                rd_word = st_ff.hist_data;
            `PRS_ADDR_AGING:
                rd_word = {16'h0000, age_addr_in};
            `PRS_ADDR_LATE:
                rd_word = {27'h0000000, st_ff.late_flags};
            `PRS_ADDR_WLAN_A:
                rd_word = 32'h00000000;
            `PRS_ADDR_WLAN_B:
                rd_word = 32'h00000000;
            `PRS_ADDR_DUP_A:
                rd_word = evt.dup_cnt[0];
            `PRS_ADDR_DUP_B:
                rd_word = evt.dup_cnt[1];
            `PRS_ADDR_LOW_A:
                rd_word = evt.low_cnt[0];
            `PRS_ADDR_LOW_B:
                rd_word = evt.low_cnt[1];
            `PRS_ADDR_OOS_A:
                rd_word = evt.oos_cnt;
            `PRS_ADDR_CONFIG:
                rd_word = cfg_word;
            `PRS_ADDR_IRQ_STAT:
                rd_word = {28'h0000000, st_ff.irq_stat};
            `PRS_ADDR_IRQ_MASK:
                rd_word = {28'h0000000, st_ff.irq_mask};
            default:
                addr_hit = 1'b0;
        endcase
    end

    // ======================================================================
    // event and clear vectors
    always_comb
    begin
        irq_evt = 4'h0;
        irq_evt[`PRS_IRQ_LATE_BIT] = |evt.late_set;
        irq_evt[`PRS_IRQ_DUP_BIT] = evt.dup_hit;
        irq_evt[`PRS_IRQ_LOW_BIT] = evt.low_hit;
        irq_evt[`PRS_IRQ_OOS_BIT] = evt.oos_hit;
        // a status read clears only the bits it reported in its setup cycle
        irq_clr = 4'h0;
        if (apb_rd && paddr_in == `PRS_ADDR_IRQ_STAT)
            irq_clr = st_ff.prdata[`PRS_NUM_IRQ-1:0];
        // write-one-to-clear of late flags, low byte lane only
        late_clr = 5'h00;
        if (apb_wr && paddr_in == `PRS_ADDR_LATE && pstrb_in[0])
            late_clr = pwdata_in[`PRS_NUM_PORTS-1:0];
    end

    // ======================================================================
    // next state of the register bank
    always_comb
    begin
        nxt_st = st_ff;
        // setup phase captures the answer so prdata comes from a flop
        if (apb_setup)
        begin
            nxt_st.prdata = rd_word;
            nxt_st.pslverr = ~addr_hit;
        end
        // software writes in the access phase
        if (apb_wr)
        begin
            case (paddr_in)
                `PRS_ADDR_HIST_DATA:
                    nxt_st.hist_data = strb_merge(st_ff.hist_data, pwdata_in, pstrb_in);
                `PRS_ADDR_CONFIG:
                begin
                    nxt_st.enable = cfg_new[`PRS_CFG_ENA_BIT];
                    nxt_st.dup_window = cfg_new[`PRS_CFG_WIN_MSB:`PRS_CFG_WIN_LSB];
                end
                `PRS_ADDR_IRQ_MASK:
                    if (pstrb_in[0])
                        nxt_st.irq_mask = pwdata_in[`PRS_NUM_IRQ-1:0];
                default:
                    nxt_st.hist_data = st_ff.hist_data;
            endcase
        end
        // a completed memory read wins over a same-cycle software write
        if (hist_rd_done_in)
            nxt_st.hist_data = hist_rd_data_in;
        // sticky late flags, a new event wins over a clear
        nxt_st.late_flags = (st_ff.late_flags & ~late_clr) | evt.late_set;
        // disabled redundancy holds every late flag at zero
        if (!st_ff.enable)
            nxt_st.late_flags = 5'h00;
        // sticky interrupt status, set wins over the read clear
        nxt_st.irq_stat = (st_ff.irq_stat & ~irq_clr) | irq_evt;
        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
    end

    // ======================================================================
    // state register
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            st_ff <= '0;
            st_ff.hist_data <= `PRS_RST_HIST_DATA;
            st_ff.enable <= `PRS_RST_ENABLE;
            st_ff.dup_window <= `PRS_RST_DUP_WINDOW;
            st_ff.irq_mask <= `PRS_RST_IRQ_MASK;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ======================================================================
    // outputs
    assign prdata_out = st_ff.prdata;
    assign pready_out = 1'b1; // zero wait states
    assign pslverr_out = apb_access & st_ff.pslverr;
    assign irq_out = st_ff.irq;
    assign hist_wr_data_out = st_ff.hist_data;
    assign redundancy_enable_out = st_ff.enable;
    assign duplicate_window_out = st_ff.dup_window;
    assign tx_dup_out = evt.tx_dup;
    assign tx_rct_out = evt.tx_rct;

endmodule // prs_redundancy_stats_regs
`default_nettype wire

// file: prs_redundancy_stats_regs_props.sv
// concurrent checks on the ports of the redundancy statistics register bank
`timescale 1ns/10ps
`default_nettype none
`include "prs_cfg.svh"
module prs_stats_props
    import prs_pkg::*;
(
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic hist_rd_done_in,
    input wire logic [31:0] hist_rd_data_in,
    input wire logic [31:0] hist_wr_data_out,
    input wire logic [15:0] age_addr_in,
    input wire logic redundancy_enable_out,
    input wire logic [`PRS_NUM_PORTS-1:0] fwd_in,
    input wire logic [`PRS_NUM_PORTS-1:0] lookup_done_in,
    input wire logic [`PRS_NUM_PORTS-1:0] tx_dup_out,
    input wire logic [`PRS_NUM_PORTS-1:0] tx_rct_out
);
    // ======================================================================
    // bus phase decode
    logic rd_setup;
    logic hist_wr;
    assign rd_setup = psel_in && !penable_in && !pwrite_in;
    assign hist_wr = psel_in && penable_in && pwrite_in && (paddr_in == `PRS_ADDR_HIST_DATA);

    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    // ======================================================================
    // history data, transmit decision and read-back fields
    a_hist_load: assert property (hist_rd_done_in |=>
        hist_wr_data_out == $past(hist_rd_data_in))
        else $error("history data not loaded by memory read");
    a_hist_hold: assert property (!hist_rd_done_in && !hist_wr |=>
        $stable(hist_wr_data_out))
        else $error("history data changed without a cause");
    a_dup_follows: assert property (1'b1 |=>
        tx_dup_out == ($past(fwd_in) & {`PRS_NUM_PORTS{$past(redundancy_enable_out)}}))
        else $error("duplicate pulse does not follow enabled forward");
    a_rct_lookup: assert property (tx_dup_out != 0 |->
        tx_rct_out == (tx_dup_out & $past(lookup_done_in)))
        else $error("trailer decision does not match lookup state");
    a_aging_read: assert property (rd_setup && paddr_in == `PRS_ADDR_AGING |=>
        prdata_out == {16'h0000, $past(age_addr_in)})
        else $error("aging index read wrong");
    a_wlan_zero: assert property (rd_setup && (paddr_in == `PRS_ADDR_WLAN_A ||
        paddr_in == `PRS_ADDR_WLAN_B) |=> prdata_out == 32'h00000000)
        else $error("wrong lan register not zero");
    a_late_width: assert property (rd_setup && paddr_in == `PRS_ADDR_LATE |=>
        prdata_out[31:5] == 27'h0000000)
        else $error("late flag read has upper bits set");
    a_late_disabled: assert property (rd_setup && paddr_in == `PRS_ADDR_LATE &&
        !$past(redundancy_enable_out) |=> prdata_out[4:0] == 5'h00)
        else $error("late flags set while redundancy disabled");

    // ======================================================================
    // main scenarios reached
    c_late_event: cover property (tx_dup_out != 0 && tx_rct_out != tx_dup_out);
    c_hist_load: cover property (hist_rd_done_in);
    c_late_off: cover property (rd_setup && paddr_in == `PRS_ADDR_LATE && !redundancy_enable_out);
endmodule // prs_stats_props

bind prs_redundancy_stats_regs prs_stats_props i_prs_stats_props (
    .clock_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out,
    .hist_rd_done_in, .hist_rd_data_in, .hist_wr_data_out, .age_addr_in,
    .redundancy_enable_out, .fwd_in, .lookup_done_in, .tx_dup_out, .tx_rct_out
);
`default_nettype wire

// file: prs_redundancy_stats_regs_tb_top.sv
// self-checking bench for the redundancy statistics register bank
`timescale 1ns/10ps
`default_nettype none
`include "prs_cfg.svh"
module prs_redundancy_stats_regs_tb_top
    import prs_pkg::*;
;
    logic clock_in, rstn_in, psel_in, penable_in, pwrite_in, hist_rd_done_in;
    logic [31:0] paddr_in, pwdata_in, hist_rd_data_in, prdata_out, hist_wr_data_out;
    logic [3:0] pstrb_in;
    logic pready_out, pslverr_out, irq_out, redundancy_enable_out;
    logic [15:0] age_addr_in, duplicate_window_out, seq_a_in, last_a_in, seq_b_in, last_b_in;
    logic [4:0] fwd_in, lookup_done_in, tx_dup_out, tx_rct_out;
    logic acc_a_in, dup_a_in, unexp_a_in, acc_b_in, dup_b_in, unexp_b_in;
    logic [31:0] rd_data;
    logic rd_err;
    int err_count;
    int checks_done;

    prs_redundancy_stats_regs i_prs_redundancy_stats_regs (
        .clock_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .irq_out, .hist_rd_done_in,
        .hist_rd_data_in, .hist_wr_data_out, .age_addr_in, .redundancy_enable_out,
        .duplicate_window_out, .fwd_in, .lookup_done_in, .tx_dup_out, .tx_rct_out,
        .acc_a_in, .dup_a_in, .unexp_a_in, .seq_a_in, .last_a_in, .acc_b_in, .dup_b_in,
        .unexp_b_in, .seq_b_in, .last_b_in
    );

    // 50 MHz clock
    initial
    begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end

    // ======================================================================
    // compare, verdict and bus tasks
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        @(posedge clock_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= addr;
        pwdata_in <= wdata;
        @(posedge clock_in);
        penable_in <= 1'b1;
        do @(posedge clock_in); while (pready_out !== 1'b1);
        rd_data = prdata_out;
        rd_err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        pwdata_in <= ~wdata;
    endtask

    task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h00000000);
        check32(rd_data, exp);
    endtask

    // one forward pulse per port, then the transmit pulses one edge later
    task automatic fwd_chk(input logic [4:0] f, input logic [4:0] d, input logic [4:0] dup,
                           input logic [4:0] rct);
        @(posedge clock_in);
        fwd_in <= f;
        lookup_done_in <= d;
        @(posedge clock_in);
        fwd_in <= 5'h00;
        lookup_done_in <= ~d;
        #1;
        check32({27'h0, tx_dup_out}, {27'h0, dup});
        check32({27'h0, tx_rct_out}, {27'h0, rct});
    endtask

    // one cycle of lan events: acc_a dup_a unexp_a acc_b dup_b unexp_b
    task automatic frame(input logic [5:0] f, input logic [15:0] sa, input logic [15:0] la,
                         input logic [15:0] sb, input logic [15:0] lb);
        @(posedge clock_in);
        {acc_a_in, dup_a_in, unexp_a_in, acc_b_in, dup_b_in, unexp_b_in} <= f;
        {seq_a_in, last_a_in, seq_b_in, last_b_in} <= {sa, la, sb, lb};
        @(posedge clock_in);
        {acc_a_in, dup_a_in, unexp_a_in, acc_b_in, dup_b_in, unexp_b_in} <= 6'h00;
        {seq_a_in, last_a_in, seq_b_in, last_b_in} <= ~{sa, la, sb, lb};
    endtask

    // ======================================================================
    // scenarios
    task automatic t_reset();
        logic [31:0] al [10] = '{`PRS_ADDR_HIST_DATA, `PRS_ADDR_LATE, `PRS_ADDR_WLAN_A,
            `PRS_ADDR_WLAN_B, `PRS_ADDR_DUP_A, `PRS_ADDR_DUP_B, `PRS_ADDR_LOW_A,
            `PRS_ADDR_LOW_B, `PRS_ADDR_OOS_A, `PRS_ADDR_LOW_B};
        foreach (al[i]) rd_chk(al[i], 32'h00000000);
        rd_chk(`PRS_ADDR_AGING, 32'h0000beef);
        apb(1'b1, `PRS_ADDR_DUP_A, 32'hffffffff);
        rd_chk(`PRS_ADDR_DUP_A, 32'h00000000);
        apb(1'b1, `PRS_ADDR_WLAN_B, 32'hffffffff);
        rd_chk(`PRS_ADDR_WLAN_B, 32'h00000000);
        // unmapped hole between data and aging registers
        apb(1'b0, 32'h44053d28, 32'h00000000);
        check32({31'h0, rd_err}, 32'h00000001);
        check32(rd_data, 32'h00000000);
    endtask

    task automatic t_hist();
        apb(1'b1, `PRS_ADDR_HIST_DATA, 32'h5a5ac3c3);
        rd_chk(`PRS_ADDR_HIST_DATA, 32'h5a5ac3c3);
        check32(hist_wr_data_out, 32'h5a5ac3c3);
        @(posedge clock_in);
        hist_rd_done_in <= 1'b1;
        hist_rd_data_in <= 32'hcafef00d;
        @(posedge clock_in);
        hist_rd_done_in <= 1'b0;
        hist_rd_data_in <= 32'h35010ff2;
        rd_chk(`PRS_ADDR_HIST_DATA, 32'hcafef00d);
    endtask

    task automatic t_late();
        apb(1'b1, `PRS_ADDR_CONFIG, 32'h00800001);
        apb(1'b1, `PRS_ADDR_IRQ_MASK, 32'h00000001);
        check32({duplicate_window_out, 15'h0, redundancy_enable_out}, 32'h00800001);
        fwd_chk(5'h05, 5'h01, 5'h05, 5'h01);
        repeat (3) @(posedge clock_in);
        #1;
        check32({31'h0, irq_out}, 32'h00000001);
        rd_chk(`PRS_ADDR_LATE, 32'h00000004);
        apb(1'b1, `PRS_ADDR_LATE, 32'h0000001b);
        rd_chk(`PRS_ADDR_LATE, 32'h00000004);
        apb(1'b1, `PRS_ADDR_LATE, 32'h00000004);
        rd_chk(`PRS_ADDR_LATE, 32'h00000000);
        rd_chk(`PRS_ADDR_IRQ_STAT, 32'h00000001);
        repeat (2) @(posedge clock_in);
        #1;
        check32({31'h0, irq_out}, 32'h00000000);
        fwd_chk(5'h10, 5'h00, 5'h10, 5'h00);
        rd_chk(`PRS_ADDR_LATE, 32'h00000010);
        apb(1'b1, `PRS_ADDR_CONFIG, 32'h00800000);
        rd_chk(`PRS_ADDR_LATE, 32'h00000000);
        fwd_chk(5'h1f, 5'h00, 5'h00, 5'h00);
        rd_chk(`PRS_ADDR_LATE, 32'h00000000);
        apb(1'b1, `PRS_ADDR_IRQ_MASK, 32'h00000000);
    endtask

    // window 0x80: distance 0x80 is inside, wrap-around distance 0x110 is below
    task automatic t_counts();
        frame(6'h10, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        frame(6'h10, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        frame(6'h12, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        frame(6'h20, 16'hff00, 16'h0010, 16'h0000, 16'h0000);
        frame(6'h20, 16'h0080, 16'h0100, 16'h0000, 16'h0000);
        frame(6'h28, 16'h0050, 16'h0100, 16'h0000, 16'h0000);
        frame(6'h2d, 16'h0110, 16'h0100, 16'h0000, 16'h0200);
        rd_chk(`PRS_ADDR_DUP_A, 32'h00000003);
        rd_chk(`PRS_ADDR_DUP_B, 32'h00000001);
        rd_chk(`PRS_ADDR_LOW_A, 32'h00000002);
        rd_chk(`PRS_ADDR_LOW_B, 32'h00000001);
        rd_chk(`PRS_ADDR_OOS_A, 32'h00000003);
        rd_chk(`PRS_ADDR_WLAN_A, 32'h00000000);
    endtask

    // ======================================================================
    // main sequence
    initial
    begin
        {rstn_in, psel_in, penable_in, pwrite_in, hist_rd_done_in, fwd_in, lookup_done_in} = '0;
        {acc_a_in, dup_a_in, unexp_a_in, acc_b_in, dup_b_in, unexp_b_in} = '0;
        {paddr_in, pwdata_in, hist_rd_data_in} = '0;
        {seq_a_in, last_a_in, seq_b_in, last_b_in} = '0;
        pstrb_in = 4'hf;
        age_addr_in = 16'hbeef;
        err_count = 0;
        checks_done = 0;
        repeat (4) @(posedge clock_in);
        rstn_in <= 1'b1;
        t_reset();
        t_hist();
        t_late();
        t_counts();
        tally_and_finish();
    end

    // hang guard, far beyond the roughly 150 cycles the scenarios need
    initial
    begin
        #200000;
        err_count++;
        tally_and_finish();
    end
endmodule // prs_redundancy_stats_regs_tb_top
`default_nettype wire
